/* hw/pdcap_capture.sv */
// Slot power limit capture register for the upstream port.
// Assumes the message strobe is a one-cycle pulse on clk_i.
`timescale 1ns/1ps
module pdcap_capture (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic is_upstream_i,
  input wire logic msg_valid_i,
  input wire logic [7:0] msg_value_i,
  input wire logic [1:0] msg_scale_i,
  output logic [7:0] value_o,
  output logic [1:0] scale_o
);
  import pdcap_pkg::*;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      value_o <= PLV_RESET;
      scale_o <= PLS_RESET;
    end else if (!is_upstream_i) begin
      // Downstream ports never hold a limit
      value_o <= PLV_RESET; // [RULE7]
      scale_o <= PLS_RESET; // [RULE8]
    end else if (msg_valid_i) begin
      value_o <= msg_value_i; // [RULE7]
      scale_o <= msg_scale_i; // [RULE8]
    end
  end
endmodule

/* hw/pdcap_top.sv */
// Device-capabilities word of one switch port, on classic Wishbone.
// Assumes port_type_i is static strap logic on clk_i; messages on clk_i.
//
// Overview of operation
// (RULE1) Max payload supported, bits 2:0, lockable writable, resets to 4.
// (RULE2) Phantom function support bits 4:3 read zero.
// (RULE3) Extended tag support bit 5, lockable writable, resets to one.
// (RULE4) Both endpoint exit latency fields read zero.
// (RULE5) Button and both indicator presence bits read zero.
// (RULE6) Role based error reporting bit 15 reads one.
// (RULE7) Upstream captures power limit value from each message; else zero.
// (RULE8) Upstream captures power limit scale from each message; else zero.
// (RULE9) Port type five is upstream, six downstream; selects capture.
// (RULE10) Reserved bits read zero; read-only field writes ignored.
// (RULE11) Lockable fields take writes only while the lock permits.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module pdcap_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] port_type_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic spl_msg_valid_i,
  input wire logic [7:0] spl_msg_value_i,
  input wire logic [1:0] spl_msg_scale_i
);
  import pdcap_pkg::*;

  logic [2:0] max_payload_supported_reg;
  logic extended_tag_support_reg;
  logic write_enable_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0] captured_power_limit_value;
  logic [1:0] captured_power_limit_scale;
  logic is_upstream;
  logic req;
  logic sel_cap;
  logic sel_lock;
  logic [31:0] device_capability_word;

  assign is_upstream = (port_type_i == PORT_TYPE_UPSTREAM); // [RULE9]
  // New request only when no ack is pending, so each access acks once
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign sel_cap = (wb_adr_i == DEV_CAP_OFFSET);
  assign sel_lock = (wb_adr_i == CAP_LOCK_OFFSET);

  pdcap_capture u_capture (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .is_upstream_i(is_upstream),
    .msg_valid_i(spl_msg_valid_i),
    .msg_value_i(spl_msg_value_i),
    .msg_scale_i(spl_msg_scale_i),
    .value_o(captured_power_limit_value),
    .scale_o(captured_power_limit_scale)
  );

  // Fixed fields are constants; reserved bits fall out as zero
  always_comb begin
    device_capability_word = 32'h0000_0000; // [RULE2] [RULE4] [RULE5] [RULE10]
    device_capability_word[MPS_MSB:MPS_LSB] = max_payload_supported_reg;
    device_capability_word[EXT_TAG_BIT] = extended_tag_support_reg;
    device_capability_word[ROLE_ERR_BIT] = ROLE_ERR_VALUE; // [RULE6]
    device_capability_word[PLV_MSB:PLV_LSB] = captured_power_limit_value;
    device_capability_word[PLS_MSB:PLS_LSB] = captured_power_limit_scale;
  end

  // Lock control: bit 0 set opens the lockable fields to writes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      write_enable_reg <= LOCK_RESET;
    end else if (req && wb_we_i && sel_lock && wb_sel_i[0]) begin
      write_enable_reg <= wb_dat_i[0];
    end
  end

  // Only the lockable fields are stored; other writes fall away
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      max_payload_supported_reg <= MPS_RESET; // [RULE1]
      extended_tag_support_reg <= EXT_TAG_RESET; // [RULE3]
    end else if (req && wb_we_i && sel_cap && wb_sel_i[0] &&
                 write_enable_reg) begin // [RULE11] [RULE10]
      max_payload_supported_reg <= wb_dat_i[MPS_MSB:MPS_LSB]; // [RULE1]
      extended_tag_support_reg <= wb_dat_i[EXT_TAG_BIT]; // [RULE3]
    end
  end

  // One wait state: ack one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req && !wb_we_i) begin
        if (sel_cap) begin
          rdata_reg <= device_capability_word;
        end else if (sel_lock) begin
          rdata_reg <= {31'h0, write_enable_reg};
        end else begin
          rdata_reg <= 32'h0000_0000;
        end
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // Port type is compared with the codes, not with is_upstream

  AST_ROLE_ERR_ONE: assert property ( // [RULE6]
    @(posedge clk_i) disable iff (sys_rst_i)
    device_capability_word[ROLE_ERR_BIT] == 1'b1)
    else $error("role based error bit not one");

  AST_PHANTOM_ZERO: assert property ( // [RULE2]
    @(posedge clk_i) disable iff (sys_rst_i)
    device_capability_word[PHANTOM_LSB+1:PHANTOM_LSB] == 2'h0)
    else $error("phantom function field not zero");

  AST_LATENCY_ZERO: assert property ( // [RULE4]
    @(posedge clk_i) disable iff (sys_rst_i)
    device_capability_word[SHALLOW_LSB+2:SHALLOW_LSB] == 3'h0 &&
    device_capability_word[DEEP_LSB+2:DEEP_LSB] == 3'h0)
    else $error("exit latency field not zero");

  AST_PRESENCE_ZERO: assert property ( // [RULE5]
    @(posedge clk_i) disable iff (sys_rst_i)
    !device_capability_word[BUTTON_BIT] &&
    !device_capability_word[ATT_LAMP_BIT] &&
    !device_capability_word[PWR_LAMP_BIT])
    else $error("presence bit not zero");

  AST_RESERVED_ZERO: assert property ( // [RULE10]
    @(posedge clk_i) disable iff (sys_rst_i)
    device_capability_word[17:16] == 2'h0 &&
    device_capability_word[31:28] == 4'h0)
    else $error("reserved bits not zero");

  // No disable here: this one is about the reset itself
  AST_RESET_VALUES: assert property ( // [RULE1] [RULE3] [RULE7] [RULE8]
    @(posedge clk_i)
    sys_rst_i |=> max_payload_supported_reg == MPS_RESET &&
    extended_tag_support_reg == EXT_TAG_RESET &&
    device_capability_word[PLS_MSB:PLV_LSB] == 10'h000)
    else $error("fields wrong after reset");

  AST_LOCK_RESET: assert property ( // [RULE11]
    @(posedge clk_i)
    sys_rst_i |=> !write_enable_reg && !wb_ack_o)
    else $error("lock open or ack high after reset");

  AST_LOCK_HOLDS: assert property ( // [RULE11]
    @(posedge clk_i) disable iff (sys_rst_i)
    !write_enable_reg |=> $stable(max_payload_supported_reg) &&
    $stable(extended_tag_support_reg))
    else $error("locked field changed");

  AST_WRITE_TAKES: assert property ( // [RULE1] [RULE3] [RULE11]
    @(posedge clk_i) disable iff (sys_rst_i)
    req && wb_we_i && sel_cap && wb_sel_i[0] && write_enable_reg |=>
    max_payload_supported_reg == $past(wb_dat_i[MPS_MSB:MPS_LSB]) &&
    extended_tag_support_reg == $past(wb_dat_i[EXT_TAG_BIT]))
    else $error("open write not stored");

  AST_NO_SEL_HOLDS: assert property ( // [RULE11]
    @(posedge clk_i) disable iff (sys_rst_i)
    req && wb_we_i && sel_cap && !wb_sel_i[0] |=>
    $stable(max_payload_supported_reg) && $stable(extended_tag_support_reg))
    else $error("field changed with byte lane off");

  AST_LOCK_WRITE: assert property ( // [RULE11]
    @(posedge clk_i) disable iff (sys_rst_i)
    req && wb_we_i && sel_lock && wb_sel_i[0] |=>
    write_enable_reg == $past(wb_dat_i[0]))
    else $error("lock write not stored");

  AST_CAPTURE: assert property ( // [RULE7] [RULE8] [RULE9]
    @(posedge clk_i) disable iff (sys_rst_i)
    port_type_i == PORT_TYPE_UPSTREAM && spl_msg_valid_i ##1
    port_type_i == PORT_TYPE_UPSTREAM |->
    device_capability_word[PLV_MSB:PLV_LSB] == $past(spl_msg_value_i) &&
    device_capability_word[PLS_MSB:PLS_LSB] == $past(spl_msg_scale_i))
    else $error("power limit not captured");

  AST_CAPTURE_HOLD: assert property ( // [RULE7] [RULE8]
    @(posedge clk_i) disable iff (sys_rst_i)
    port_type_i == PORT_TYPE_UPSTREAM && !spl_msg_valid_i ##1
    port_type_i == PORT_TYPE_UPSTREAM |->
    $stable(device_capability_word[PLS_MSB:PLV_LSB]))
    else $error("power limit moved without a message");

  AST_DOWN_ZERO: assert property ( // [RULE7] [RULE8] [RULE9]
    @(posedge clk_i) disable iff (sys_rst_i)
    port_type_i == PORT_TYPE_DOWNSTREAM ##1
    port_type_i == PORT_TYPE_DOWNSTREAM |->
    device_capability_word[PLS_MSB:PLV_LSB] == 10'h000)
    else $error("downstream power limit not zero");

  AST_ACK_AFTER_REQ: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    req |=> wb_ack_o)
    else $error("request not acked after one cycle");

  AST_ACK_ONLY_REQ: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !req |=> !wb_ack_o)
    else $error("ack without a request");

  AST_ACK_PULSE: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  AST_CAP_READ: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    req && !wb_we_i && sel_cap |=>
    wb_dat_o == $past(device_capability_word))
    else $error("capability read data wrong");

  AST_LOCK_READ: assert property ( // [RULE11]
    @(posedge clk_i) disable iff (sys_rst_i)
    req && !wb_we_i && sel_lock |=>
    wb_dat_o[31:1] == 31'h0 && wb_dat_o[0] == $past(write_enable_reg))
    else $error("lock read data wrong");

  AST_UNMAPPED_ZERO: assert property ( // [RULE10]
    @(posedge clk_i) disable iff (sys_rst_i)
    req && !wb_we_i && !sel_cap && !sel_lock |=>
    wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  AST_DAT_HOLDS: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !(req && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without a read");
endmodule

/* pkg/pdcap_pkg.sv */
// Package for the port device-capabilities word: offsets, fields, resets.
// Assumes a 32-bit classic Wishbone register bus on one core clock.
package pdcap_pkg;
  localparam logic [11:0] DEV_CAP_OFFSET = 12'h044;
  localparam logic [11:0] CAP_LOCK_OFFSET = 12'h0f0;
  localparam logic [3:0] PORT_TYPE_UPSTREAM = 4'h5;
  localparam logic [3:0] PORT_TYPE_DOWNSTREAM = 4'h6;
  localparam int MPS_LSB = 0;
  localparam int MPS_MSB = 2;
  localparam int PHANTOM_LSB = 3;
  localparam int EXT_TAG_BIT = 5;
  localparam int SHALLOW_LSB = 6;
  localparam int DEEP_LSB = 9;
  localparam int BUTTON_BIT = 12;
  localparam int ATT_LAMP_BIT = 13;
  localparam int PWR_LAMP_BIT = 14;
  localparam int ROLE_ERR_BIT = 15;
  localparam int PLV_LSB = 18;
  localparam int PLV_MSB = 25;
  localparam int PLS_LSB = 26;
  localparam int PLS_MSB = 27;
  localparam logic [2:0] MPS_RESET = 3'h4;
  localparam logic EXT_TAG_RESET = 1'b1;
  localparam logic ROLE_ERR_VALUE = 1'b1;
  localparam logic [7:0] PLV_RESET = 8'h00;
  localparam logic [1:0] PLS_RESET = 2'h0;
  localparam logic LOCK_RESET = 1'b0;
endpackage

/* sim/pdcap_msg_src.sv */
// Upstream link partner: sends slot power limit messages as one-cycle pulses.
// Assumes the caller is on clk_i; payload is not held after the pulse.
`timescale 1ns/1ps
module pdcap_msg_src (
  input wire logic clk_i,
  output logic valid_o,
  output logic [7:0] value_o,
  output logic [1:0] scale_o
);
  initial begin
    valid_o = 1'b0;
    value_o = 8'h00;
    scale_o = 2'h0;
  end
  task automatic send(input logic [7:0] v, input logic [1:0] s);
    @(posedge clk_i);
    valid_o <= 1'b1;
    value_o <= v;
    scale_o <= s;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Inverted payload so a late capture cannot match by chance
    value_o <= ~v;
    scale_o <= ~s;
  endtask
endmodule

/* sim/tb_pdcap_top.sv */
// Testbench for the device-capabilities word over classic Wishbone.
// Assumes pdcap_pkg and the link partner model are compiled first.
`timescale 1ns/1ps
module tb_pdcap_top;
  import pdcap_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] port_type_i = PORT_TYPE_UPSTREAM;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, spl_msg_valid_i;
  logic [7:0] spl_msg_value_i;
  logic [1:0] spl_msg_scale_i;
  int n_errors = 0;
  int samples_checked = 0;
  pdcap_top u_pdcap_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .port_type_i(port_type_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .spl_msg_valid_i(spl_msg_valid_i), .spl_msg_value_i(spl_msg_value_i),
    .spl_msg_scale_i(spl_msg_scale_i));
  pdcap_msg_src u_pdcap_msg_src (.clk_i(clk_i), .valid_o(spl_msg_valid_i),
    .value_o(spl_msg_value_i), .scale_o(spl_msg_scale_i));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  function automatic logic [31:0] exp_word(input logic [2:0] mps,
    input logic extended_tag_support, input logic [7:0] plv, input logic [1:0] pls);
    return {4'h0, pls, plv, 2'h0, 1'b1, 9'h000, extended_tag_support, 2'h0, mps};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb_cycle(input logic we, input logic [11:0] adr,
    input logic [3:0] sel, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      // A missing ack is a failure; end the run here
      n_errors++;
      finish_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
    wb_cycle(1'b0, adr, 4'hf, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #40000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(DEV_CAP_OFFSET, exp_word(3'h4, 1'b1, 8'h00, 2'h0));
    wb_cycle(1'b1, DEV_CAP_OFFSET, 4'hf, 32'hffff_ffff);
    rd_chk(DEV_CAP_OFFSET, exp_word(3'h4, 1'b1, 8'h00, 2'h0));
    wb_cycle(1'b1, CAP_LOCK_OFFSET, 4'hf, 32'h0000_0001);
    rd_chk(CAP_LOCK_OFFSET, 32'h0000_0001);
    // Byte 0 disabled: lockable bits must not move even with lock open
    wb_cycle(1'b1, DEV_CAP_OFFSET, 4'he, 32'hffff_fff8);
    rd_chk(DEV_CAP_OFFSET, exp_word(3'h4, 1'b1, 8'h00, 2'h0));
    wb_cycle(1'b1, DEV_CAP_OFFSET, 4'hf, 32'hffff_ffff);
    rd_chk(DEV_CAP_OFFSET, exp_word(3'h7, 1'b1, 8'h00, 2'h0));
    wb_cycle(1'b1, DEV_CAP_OFFSET, 4'hf, 32'h0000_0000);
    rd_chk(DEV_CAP_OFFSET, exp_word(3'h0, 1'b0, 8'h00, 2'h0));
    wb_cycle(1'b1, CAP_LOCK_OFFSET, 4'hf, 32'h0000_0000);
    wb_cycle(1'b1, DEV_CAP_OFFSET, 4'hf, 32'h0000_0027);
    rd_chk(DEV_CAP_OFFSET, exp_word(3'h0, 1'b0, 8'h00, 2'h0));
    rd_chk(12'h100, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      u_pdcap_msg_src.send({~i[1:0], 6'h19}, i[1:0]);
      rd_chk(DEV_CAP_OFFSET, exp_word(3'h0, 1'b0, {~i[1:0], 6'h19},
        i[1:0]));
    end
    u_pdcap_msg_src.send(8'hff, 2'h3);
    rd_chk(DEV_CAP_OFFSET, exp_word(3'h0, 1'b0, 8'hff, 2'h3));
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    port_type_i <= PORT_TYPE_DOWNSTREAM;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    u_pdcap_msg_src.send(8'h7e, 2'h3);
    rd_chk(DEV_CAP_OFFSET, exp_word(3'h4, 1'b1, 8'h00, 2'h0));
    rd_chk(CAP_LOCK_OFFSET, 32'h0000_0000);
    finish_test();
  end
endmodule
